// ---- hw/spr_sector_protection_regs.sv ----
/*
  Sector protection register block of a serial flash: mode register,
  hidden secret value, guard lock and per-sector guard access.
  Assumes a serial front end on ref_clk that delivers each decoded command
  as a one-cycle strobe and owns the write-enable latch.
*/
`timescale 1ns/1ns
`include "spr_defs.svh"

module spr_sector_protection_regs
  import spr_pkg::*;
#(
  parameter logic [15:0] PART_MODE_DEFAULT = 16'hffff
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic powerOnReset_n,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire spr_sector_t cmdSector,
  input wire logic [63:0] cmdData,
  input wire logic writeEnableLatch,
  input wire spr_sector_t chkSector,
  output logic chkDenied,
  output logic rspValid,
  output logic rspRefused,
  output logic [63:0] rspData,
  output logic secretModeActive,
  output logic stickyModeActive,
  output logic nvGuardFreeze
);

  // ----------------------------------------------------------------
  // decode and acceptance
  // ----------------------------------------------------------------
  // reserved defaults
  localparam logic [15:0] MODE_INIT =
    `SPR_MODE_FIXED_ONES | (PART_MODE_DEFAULT & `SPR_MODE_PART_MASK);

  spr_guard_if guard();

  spr_cmd_t kind;
  logic [15:0] modeValue;
  logic [63:0] secretValue;
  logic lock_q;
  spr_lock_state_t lkState_q;
  logic modeBothZero;
  logic nvChange;
  logic refuse;
  logic accept;
  logic modeProg;
  logic secretProg;

  assign kind = cmdValid ? sprDecode(cmdCode) : SPR_NONE;
  assign nvChange = kind == SPR_MODE_PG || kind == SPR_SECRET_PG
                    || kind == SPR_NV_PG || kind == SPR_NV_ER;
  assign modeBothZero = !(modeValue[`SPR_SECRET_MODE_BIT] && cmdData[`SPR_SECRET_MODE_BIT])
                        && !(modeValue[`SPR_STICKY_MODE_BIT] && cmdData[`SPR_STICKY_MODE_BIT]);

  // nonvolatile changes without the latch are dropped, not queued
  always_comb begin
    refuse = 1'b0;
    if (nvChange && !writeEnableLatch) begin
      refuse = 1'b1;
    end
    if (kind == SPR_MODE_PG && modeBothZero) begin
      refuse = 1'b1;
    end
    // a hidden secret cannot be reprogrammed either
    if (kind == SPR_SECRET_PG && secretModeActive) begin
      refuse = 1'b1;
    end
    if ((kind == SPR_NV_PG || kind == SPR_NV_ER) && !lock_q) begin
      refuse = 1'b1;
    end
  end

  assign accept = kind != SPR_NONE && !refuse;
  assign modeProg = accept && kind == SPR_MODE_PG;
  assign secretProg = accept && kind == SPR_SECRET_PG;

  // ----------------------------------------------------------------
  // one-time-programmable storage
  // ----------------------------------------------------------------
  // mode word storage
  spr_otp_word #(
    .WIDTH(`SPR_MODE_WIDTH),
    .INIT(MODE_INIT)
  ) u_mode (
    .ref_clk(ref_clk),
    .powerOnReset_n(powerOnReset_n),
    .progValid(modeProg),
    .progData(cmdData[15:0]),
    .value(modeValue)
  );

  spr_otp_word #(
    .WIDTH(`SPR_SECRET_WIDTH),
    .INIT(`SPR_SECRET_RESET)
  ) u_secret (
    .ref_clk(ref_clk),
    .powerOnReset_n(powerOnReset_n),
    .progValid(secretProg),
    .progData(cmdData),
    .value(secretValue)
  );

  assign secretModeActive = !modeValue[`SPR_SECRET_MODE_BIT];
  assign stickyModeActive = !modeValue[`SPR_STICKY_MODE_BIT];

  // ----------------------------------------------------------------
  // guard lock
  // ----------------------------------------------------------------
  // the mode word cannot be used under async reset, so the lock starts
  // frozen and takes its mode default on the first edge after release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lkState_q <= SPR_LK_LOAD;
    end else begin
      lkState_q <= SPR_LK_RUN;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= 1'b0;
    end else begin
      case (lkState_q)
        SPR_LK_LOAD: lock_q <= modeValue[`SPR_SECRET_MODE_BIT];
        SPR_LK_RUN: begin
          if (accept && kind == SPR_LOCK_WR && !cmdData[0]) begin
            lock_q <= 1'b0;
          end
        end
        default: lock_q <= 1'b0;
      endcase
    end
  end

  assign nvGuardFreeze = !lock_q;

  // ----------------------------------------------------------------
  // sector guards
  // ----------------------------------------------------------------
  // one sector per command, except nonvolatile erase, which frees every sector
  assign guard.sector = cmdSector;
  assign guard.nvProgram = accept && kind == SPR_NV_PG;
  assign guard.nvErase = accept && kind == SPR_NV_ER;
  assign guard.volWrite = accept && kind == SPR_VOL_WR;
  // only FFh frees a sector; any other pattern is taken as protect
  assign guard.volValue = cmdData[7:0] == `SPR_GUARD_OFF;
  assign guard.chkSector = chkSector;
  assign chkDenied = guard.chkDenied;

  spr_sector_guard_array u_array (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .powerOnReset_n(powerOnReset_n),
    .guard(guard.array)
  );

  // ----------------------------------------------------------------
  // responses
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rspValid <= 1'b0;
      rspRefused <= 1'b0;
    end else begin
      rspValid <= kind != SPR_NONE;
      rspRefused <= kind != SPR_NONE && refuse;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rspData <= 64'h0;
    end else begin
      case (kind)
        SPR_MODE_RD: rspData <= {48'h0, modeValue};
        SPR_SECRET_RD: rspData <= secretModeActive ? `SPR_SECRET_RESET : secretValue;
        SPR_LOCK_RD: rspData <= {56'h0, `SPR_LOCK_RSVD, lock_q};
        SPR_NV_RD: rspData <= {56'h0, guard.nvBit ? `SPR_GUARD_OFF : `SPR_GUARD_ON};
        SPR_VOL_RD: rspData <= {56'h0, guard.volBit ? `SPR_GUARD_OFF : `SPR_GUARD_ON};
        default: rspData <= rspData;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_modeRead;
    kind == SPR_MODE_RD |=> rspValid && rspData == {48'h0, $past(modeValue)};
  endproperty
  a_modeRead: assert property (p_modeRead) else $error("mode read wrong");

  property p_secretHidden;
    kind == SPR_SECRET_RD && secretModeActive |=> rspData == `SPR_SECRET_RESET;
  endproperty
  a_secretHidden: assert property (p_secretHidden) else $error("secret leaked");

  property p_lockRead;
    kind == SPR_LOCK_RD |=> rspData[63:1] == 63'h0 && rspData[0] == $past(lock_q);
  endproperty
  a_lockRead: assert property (p_lockRead) else $error("lock read wrong");

  property p_lockDefault;
    lkState_q == SPR_LK_LOAD |=> lock_q == $past(modeValue[`SPR_SECRET_MODE_BIT]);
  endproperty
  a_lockDefault: assert property (p_lockDefault) else $error("lock default wrong");

  property p_frozen;
    !lock_q |-> !guard.nvProgram && !guard.nvErase;
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen guard changed");

  property p_lockStays;
    !lock_q && lkState_q == SPR_LK_RUN |=> !lock_q [*2];
  endproperty
  a_lockStays: assert property (p_lockStays) else $error("lock reopened");

  property p_nvRead;
    kind == SPR_NV_RD |=> rspData[7:0] == ($past(guard.nvBit) ? 8'hff : 8'h00);
  endproperty
  a_nvRead: assert property (p_nvRead) else $error("guard read wrong");

  property p_exclusive;
    !(secretModeActive && stickyModeActive);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("both modes set");

  property p_refuseNoWel;
    nvChange && !writeEnableLatch |=> rspValid && rspRefused;
  endproperty
  a_refuseNoWel: assert property (p_refuseNoWel) else $error("write without latch");

  property p_answer;
    kind != SPR_NONE |=> rspValid && rspRefused == $past(refuse);
  endproperty
  a_answer: assert property (p_answer) else $error("answer pulse wrong");

  property p_volRead;
    kind == SPR_VOL_RD |=> rspData[7:0] == ($past(guard.volBit) ? 8'hff : 8'h00);
  endproperty
  a_volRead: assert property (p_volRead) else $error("volatile read wrong");

  property p_nvLocked;
    (kind == SPR_NV_PG || kind == SPR_NV_ER) && !lock_q |=> rspRefused;
  endproperty
  a_nvLocked: assert property (p_nvLocked) else $error("frozen accepted");

  // power-on reset alone may restore the factory word, so both resets disable
  property p_secretHold;
    disable iff (!reset_n || !powerOnReset_n) secretModeActive |=> secretModeActive;
  endproperty
  a_secretHold: assert property (p_secretHold) else $error("password mode left");

  property p_stickyHold;
    disable iff (!reset_n || !powerOnReset_n) stickyModeActive |=> stickyModeActive;
  endproperty
  a_stickyHold: assert property (p_stickyHold) else $error("persistent mode left");

  c_secretMode: cover property (modeProg ##1 secretModeActive);
  c_stickyMode: cover property (modeProg ##1 stickyModeActive);
  c_freeze: cover property (lock_q ##1 !lock_q);
  c_nvRefused: cover property (kind == SPR_NV_PG && !lock_q);
  c_denied: cover property (chkDenied);

endmodule

// ---- include/spr_defs.svh ----
/*
  Constants of the sector protection register block: command codes, field
  positions, reset values and sizes.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define SPR_CMD_MODE_RD 8'h2b
`define SPR_CMD_MODE_PG 8'h2f
`define SPR_CMD_SECRET_RD 8'he7
`define SPR_CMD_SECRET_PG 8'he8
`define SPR_CMD_LOCK_RD 8'ha7
`define SPR_CMD_LOCK_WR 8'ha6
`define SPR_CMD_NV_RD 8'he2
`define SPR_CMD_NV_PG 8'he3
`define SPR_CMD_NV_ER 8'he4
`define SPR_CMD_VOL_RD 8'he0
`define SPR_CMD_VOL_WR 8'he1

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SPR_MODE_WIDTH 16
`define SPR_SECRET_WIDTH 64
`define SPR_SECRET_MODE_BIT 2
`define SPR_STICKY_MODE_BIT 1
`define SPR_MODE_FIXED_ONES 16'hfe47
`define SPR_MODE_PART_MASK 16'h01b8
`define SPR_SECRET_RESET 64'hffff_ffff_ffff_ffff
`define SPR_LOCK_RSVD 7'h00
`define SPR_GUARD_ON 8'h00
`define SPR_GUARD_OFF 8'hff
`define SPR_SECTOR_COUNT 256
`define SPR_SECTOR_BITS 8

`endif

// ---- include/spr_pkg.sv ----
/*
  Types and command decoding shared by the sector protection modules.
  Assumes spr_defs.svh is on the include path.
*/
`include "spr_defs.svh"

package spr_pkg;

  typedef logic [`SPR_SECTOR_BITS-1:0] spr_sector_t;

  typedef enum logic [3:0] {
    SPR_NONE, SPR_MODE_RD, SPR_MODE_PG, SPR_SECRET_RD, SPR_SECRET_PG,
    SPR_LOCK_RD, SPR_LOCK_WR, SPR_NV_RD, SPR_NV_PG, SPR_NV_ER,
    SPR_VOL_RD, SPR_VOL_WR
  } spr_cmd_t;

  typedef enum logic {SPR_LK_LOAD, SPR_LK_RUN} spr_lock_state_t;

  function automatic spr_cmd_t sprDecode(input logic [7:0] code);
    case (code)
      `SPR_CMD_MODE_RD: sprDecode = SPR_MODE_RD;
      `SPR_CMD_MODE_PG: sprDecode = SPR_MODE_PG;
      `SPR_CMD_SECRET_RD: sprDecode = SPR_SECRET_RD;
      `SPR_CMD_SECRET_PG: sprDecode = SPR_SECRET_PG;
      `SPR_CMD_LOCK_RD: sprDecode = SPR_LOCK_RD;
      `SPR_CMD_LOCK_WR: sprDecode = SPR_LOCK_WR;
      `SPR_CMD_NV_RD: sprDecode = SPR_NV_RD;
      `SPR_CMD_NV_PG: sprDecode = SPR_NV_PG;
      `SPR_CMD_NV_ER: sprDecode = SPR_NV_ER;
      `SPR_CMD_VOL_RD: sprDecode = SPR_VOL_RD;
      `SPR_CMD_VOL_WR: sprDecode = SPR_VOL_WR;
      default: sprDecode = SPR_NONE;
    endcase
  endfunction

endpackage

// ---- include/spr_guard_if.sv ----
/*
  Carrier between the command logic and the per-sector guard array.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`include "spr_defs.svh"

interface spr_guard_if;
  logic [`SPR_SECTOR_BITS-1:0] sector;
  logic nvProgram;
  logic nvErase;
  logic volWrite;
  logic volValue;
  logic nvBit;
  logic volBit;
  logic [`SPR_SECTOR_BITS-1:0] chkSector;
  logic chkDenied;

  modport ctrl(output sector, nvProgram, nvErase, volWrite, volValue, chkSector,
               input nvBit, volBit, chkDenied);
  modport array(input sector, nvProgram, nvErase, volWrite, volValue, chkSector,
                output nvBit, volBit, chkDenied);
endinterface

// ---- hw/spr_otp_word.sv ----
/*
  One-time-programmable word: bits only ever move from 1 to 0.
  Assumes powerOnReset_n stands for the factory state, not a user reset.
*/
`timescale 1ns/1ns

module spr_otp_word #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic ref_clk,
  input wire logic powerOnReset_n,
  input wire logic progValid,
  input wire logic [WIDTH-1:0] progData,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_q;

  always_ff @(posedge ref_clk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      value_q <= INIT;
    end else if (progValid) begin
      value_q <= value_q & progData;
    end
  end

  assign value = value_q;

  property p_noRise;
    @(posedge ref_clk) disable iff (!powerOnReset_n)
      ##1 ((value_q & ~$past(value_q)) == '0);
  endproperty
  a_noRise: assert property (p_noRise) else $error("otp bit returned to one");

endmodule

// ---- hw/spr_sector_guard_array.sv ----
/*
  Per-sector nonvolatile and volatile protection bits, with the
  program/erase permission check.
  Assumes the controller gates nonvolatile changes by the lock.
*/
`timescale 1ns/1ns
`include "spr_defs.svh"

module spr_sector_guard_array (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic powerOnReset_n,
  spr_guard_if.array guard
);

  logic [`SPR_SECTOR_COUNT-1:0] nvGuard_q;
  logic [`SPR_SECTOR_COUNT-1:0] volGuard_q;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // nonvolatile bits survive user reset; erase restores every sector
  for (genvar s = 0; s < `SPR_SECTOR_COUNT; s++) begin : g_sector
    always_ff @(posedge ref_clk or negedge powerOnReset_n) begin
      if (!powerOnReset_n) begin
        nvGuard_q[s] <= 1'b1;
      end else if (guard.nvErase) begin
        nvGuard_q[s] <= 1'b1;
      end else if (guard.nvProgram && guard.sector == s) begin
        nvGuard_q[s] <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        volGuard_q[s] <= 1'b1;
      end else if (guard.volWrite && guard.sector == s) begin
        volGuard_q[s] <= guard.volValue;
      end
    end
  end

  assign guard.nvBit = nvGuard_q[guard.sector];
  assign guard.volBit = volGuard_q[guard.sector];
  assign guard.chkDenied = !nvGuard_q[guard.chkSector] || !volGuard_q[guard.chkSector];

  property p_volWrite;
    @(posedge ref_clk) disable iff (!reset_n)
      guard.volWrite |=> volGuard_q[$past(guard.sector)] == $past(guard.volValue);
  endproperty
  a_volWrite: assert property (p_volWrite) else $error("volatile bit not written");

  property p_nvProgram;
    @(posedge ref_clk) disable iff (!powerOnReset_n)
      guard.nvProgram && !guard.nvErase |=> !nvGuard_q[$past(guard.sector)];
  endproperty
  a_nvProgram: assert property (p_nvProgram) else $error("nonvolatile bit not set");

endmodule

// ---- testbench/spr_host_model.sv ----
/*
  Host controller model: turns one call into one decoded command strobe
  and collects the answer of the protection register block.
  Assumes the block answers on the same edge that takes a command.
*/
`timescale 1ns/1ns

module spr_host_model
  import spr_pkg::*;
(
  input wire logic ref_clk,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output spr_sector_t cmdSector,
  output logic [63:0] cmdData,
  output logic writeEnableLatch,
  input wire logic rspValid,
  input wire logic rspRefused,
  input wire logic [63:0] rspData
);
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    cmdSector = 8'h00;
    cmdData = 64'h0;
    writeEnableLatch = 1'b0;
  end

  // ----------------------------------------------------------------
  // command transfer
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] code, input spr_sector_t sector,
                      input logic [63:0] data, input logic wel, output logic seen,
                      output logic refused, output logic [63:0] rdata);
    int i;
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdSector = sector;
    cmdData = data;
    writeEnableLatch = wel;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    // stale data and sector are inverted so a held value cannot pass for a live one
    cmdData = ~data;
    cmdSector = ~sector;
    writeEnableLatch = 1'b0;
    seen = 1'b0;
    refused = 1'b0;
    rdata = 64'h0;
    for (i = 0; i < 3 && !seen; i++) begin
      if (rspValid === 1'b1) begin
        seen = 1'b1;
        refused = rspRefused;
        rdata = rspData;
      end else begin
        @(negedge ref_clk);
      end
    end
  endtask
endmodule

// ---- testbench/spr_sector_protection_regs_tb.sv ----
/*
  Self-checking bench of the sector protection register block.
  Assumes the host model drives the command strobe and write-enable level.
*/
`timescale 1ns/1ns
`include "spr_defs.svh"

module spr_sector_protection_regs_tb
  import spr_pkg::*;
;
  logic ref_clk;
  logic reset_n;
  logic powerOnReset_n;
  logic cmdValid;
  logic [7:0] cmdCode;
  spr_sector_t cmdSector;
  logic [63:0] cmdData;
  logic writeEnableLatch;
  spr_sector_t chkSector;
  logic chkDenied;
  logic rspValid;
  logic rspRefused;
  logic [63:0] rspData;
  logic secretModeActive;
  logic stickyModeActive;
  logic nvGuardFreeze;
  logic seen;
  logic refd;
  logic [63:0] rd;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [63:0] PAT = 64'h0123_4567_89ab_cdef;

  spr_sector_protection_regs #(.PART_MODE_DEFAULT(16'h0000)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .powerOnReset_n(powerOnReset_n),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdSector(cmdSector), .cmdData(cmdData),
    .writeEnableLatch(writeEnableLatch), .chkSector(chkSector), .chkDenied(chkDenied),
    .rspValid(rspValid), .rspRefused(rspRefused), .rspData(rspData),
    .secretModeActive(secretModeActive), .stickyModeActive(stickyModeActive),
    .nvGuardFreeze(nvGuardFreeze)
  );

  spr_host_model HOST (
    .ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdSector(cmdSector),
    .cmdData(cmdData), .writeEnableLatch(writeEnableLatch), .rspValid(rspValid),
    .rspRefused(rspRefused), .rspData(rspData)
  );

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // checks and transfers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chkWord(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op(input logic [7:0] code, input spr_sector_t s, input logic [63:0] d,
                    input logic wel, input logic expRef);
    HOST.send(code, s, d, wel, seen, refd, rd);
    chkBit("answered", 1'b1, seen);
    chkBit("refused", expRef, refd);
  endtask

  task automatic rdChk(input logic [7:0] code, input spr_sector_t s, input logic [63:0] exp);
    op(code, s, 64'h0, 1'b0, 1'b0);
    chkWord("read data", exp, rd);
  endtask

  task automatic deny(input spr_sector_t s, input logic exp);
    @(negedge ref_clk);
    chkSector = s;
    #1;
    chkBit("denied", exp, chkDenied);
  endtask

  // por high also returns the one-time-programmable state to factory
  task automatic doReset(input logic por);
    @(negedge ref_clk);
    reset_n = 1'b0;
    powerOnReset_n = !por;
    repeat (12) @(negedge ref_clk);
    reset_n = 1'b1;
    powerOnReset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    powerOnReset_n = 1'b0;
    chkSector = 8'h00;
    doReset(1'b1);
    rdChk(`SPR_CMD_MODE_RD, 8'h00, 64'hfe47);
    rdChk(`SPR_CMD_SECRET_RD, 8'h00, `SPR_SECRET_RESET);
    rdChk(`SPR_CMD_LOCK_RD, 8'h00, 64'h1);
    chkBit("freeze", 1'b0, nvGuardFreeze);
    HOST.send(8'h00, 8'h00, 64'h0, 1'b1, seen, refd, rd);
    chkBit("ignored", 1'b0, seen);
    rdChk(`SPR_CMD_VOL_RD, 8'h05, 64'hff);
    op(`SPR_CMD_VOL_WR, 8'h05, 64'h00, 1'b0, 1'b0);
    rdChk(`SPR_CMD_VOL_RD, 8'h05, 64'h00);
    rdChk(`SPR_CMD_VOL_RD, 8'h06, 64'hff);
    deny(8'h05, 1'b1);
    deny(8'h06, 1'b0);
    op(`SPR_CMD_VOL_WR, 8'h06, 64'h5a, 1'b0, 1'b0);
    rdChk(`SPR_CMD_VOL_RD, 8'h06, 64'h00);
    deny(8'h06, 1'b1);
    rdChk(`SPR_CMD_NV_RD, 8'h09, 64'hff);
    op(`SPR_CMD_NV_PG, 8'h09, 64'h0, 1'b0, 1'b1);
    rdChk(`SPR_CMD_NV_RD, 8'h09, 64'hff);
    op(`SPR_CMD_NV_PG, 8'h09, 64'h0, 1'b1, 1'b0);
    rdChk(`SPR_CMD_NV_RD, 8'h09, 64'h00);
    deny(8'h09, 1'b1);
    op(`SPR_CMD_NV_ER, 8'h00, 64'h0, 1'b1, 1'b0);
    rdChk(`SPR_CMD_NV_RD, 8'h09, 64'hff);
    deny(8'h09, 1'b0);
    op(`SPR_CMD_MODE_PG, 8'h00, 64'hfff9, 1'b1, 1'b1);
    op(`SPR_CMD_MODE_PG, 8'h00, 64'hfffd, 1'b1, 1'b0);
    rdChk(`SPR_CMD_MODE_RD, 8'h00, 64'hfe45);
    chkBit("sticky", 1'b1, stickyModeActive);
    chkBit("secret", 1'b0, secretModeActive);
    op(`SPR_CMD_MODE_PG, 8'h00, 64'hffff, 1'b1, 1'b0);
    rdChk(`SPR_CMD_MODE_RD, 8'h00, 64'hfe45);
    op(`SPR_CMD_LOCK_WR, 8'h00, 64'h0, 1'b0, 1'b0);
    rdChk(`SPR_CMD_LOCK_RD, 8'h00, 64'h0);
    chkBit("freeze", 1'b1, nvGuardFreeze);
    op(`SPR_CMD_NV_PG, 8'h09, 64'h0, 1'b1, 1'b1);
    rdChk(`SPR_CMD_NV_RD, 8'h09, 64'hff);
    op(`SPR_CMD_LOCK_WR, 8'h00, 64'h1, 1'b0, 1'b0);
    rdChk(`SPR_CMD_LOCK_RD, 8'h00, 64'h0);
    doReset(1'b0);
    rdChk(`SPR_CMD_LOCK_RD, 8'h00, 64'h1);
    rdChk(`SPR_CMD_VOL_RD, 8'h05, 64'hff);
    rdChk(`SPR_CMD_MODE_RD, 8'h00, 64'hfe45);
    doReset(1'b1);
    op(`SPR_CMD_SECRET_PG, 8'h00, PAT, 1'b1, 1'b0);
    rdChk(`SPR_CMD_SECRET_RD, 8'h00, PAT);
    op(`SPR_CMD_SECRET_PG, 8'h00, 64'hffff_ffff_ffff_ffff, 1'b1, 1'b0);
    rdChk(`SPR_CMD_SECRET_RD, 8'h00, PAT);
    op(`SPR_CMD_MODE_PG, 8'h00, 64'hfffb, 1'b1, 1'b0);
    chkBit("secret", 1'b1, secretModeActive);
    rdChk(`SPR_CMD_SECRET_RD, 8'h00, `SPR_SECRET_RESET);
    op(`SPR_CMD_SECRET_PG, 8'h00, 64'h0, 1'b1, 1'b1);
    op(`SPR_CMD_MODE_PG, 8'h00, 64'hfffd, 1'b1, 1'b1);
    doReset(1'b0);
    rdChk(`SPR_CMD_LOCK_RD, 8'h00, 64'h0);
    chkBit("freeze", 1'b1, nvGuardFreeze);
    op(`SPR_CMD_NV_PG, 8'h03, 64'h0, 1'b1, 1'b1);
    end_sim();
  end
endmodule
